// ### src/pin_mux_params.svh
/*
 * Register offsets, reset values and implemented-bit masks of the pin mux.
 * Assumes a 32-bit APB slave with one register per aligned word.
 */
`ifndef PIN_MUX_PARAMS_SVH
`define PIN_MUX_PARAMS_SVH

// ----------------
// Register byte offsets
// ----------------
`define OFS_PA_DATA   8'h00
`define OFS_PA_DIR    8'h04
`define OFS_PA_WAKE   8'h08
`define OFS_PB_DATA   8'h0c
`define OFS_PB_DIR    8'h10
`define OFS_PA_SEL0   8'h14
`define OFS_PA_SEL1   8'h18
`define OFS_PB_SEL0   8'h1c
`define OFS_PB_SEL1   8'h20
`define OFS_SRC_CUR   8'h24

// ----------------
// Reset values
// ----------------
`define RST_PA_DATA   8'hff
`define RST_PA_DIR    8'hff
`define RST_PB_DATA   5'h1f
`define RST_PB_DIR    5'h1f
`define RST_SEL       8'h00
`define RST_SRC_CUR   8'h00
`define RST_WAKE      8'h00

// ----------------
// Implemented-bit masks of the second select registers
// ----------------
`define MASK_PA_SEL1  8'hf3
`define MASK_PB_SEL1  8'h03

`endif

// ### src/pin_mux_pkg.sv
/*
 * Types used by the pin mux design.
 * Assumes pin_mux_params.svh supplies the numeric constants.
 */
package pin_mux_pkg;

    // Function that a select field gives a pin, one-hot
    typedef enum logic [3:0] {
        FN_GPIO    = 4'b0001,
        FN_ANALOG  = 4'b0010,
        FN_TMR     = 4'b0100,
        FN_TMR_INV = 4'b1000
    } pin_fn_t;

endpackage

// ### src/port_pin_function_mux.sv
/*
 * Pin-function multiplexer for port A (8 pins) and port B (5 pins),
 * with port data/direction latches, source current selects and
 * port A falling-edge wake-up, all behind an APB slave.
 * Assumes one 100 MHz clock, synchronous reset, timer signals from
 * logic on the same clock, and pins that are asynchronous to it.
 */
// Local design decisions: the register offsets and the APB slave port.
// What the document requires
// RULE1: each port A pin pair has a 2-bit source current level, 00 min to 11 max
// RULE2: PA3 field code 01 gives op-amp non-inverting input, others GPIO
// RULE3: PA2 field 01 op-amp inverting input, 10 battery sense, else GPIO
// RULE4: PA1 field 00 GPIO, 01 op-amp output, 10 analog 1, 11 timer output
// RULE5: PA0 field 00/11 GPIO with interrupt, 01 analog 0, 10 timer output
// RULE6: PA7 field 01 selects analog channel 3, others GPIO
// RULE7: PA6 field 01 op-amp non-inverting, 10 analog 2, 11 inverted timer
// RULE8: PA4 field 01 selects battery sense, others GPIO
// RULE9: unimplemented select register bits read back as zero
// RULE10: PB3 field 01 connects touch pad two, others GPIO
// RULE11: PB2 field 01 touch pad one, 10 reference input, else GPIO
// RULE12: PB1 field 01 drives inverted timer output, others GPIO
// RULE13: PB0 field 01 drives timer output, others GPIO
// RULE14: PB4 field 01 drives timer output, others GPIO
// RULE15: software prefers battery sense on PA4, never PA2 and PA4 together
// RULE16: software selects the pin, sets up, then enables the peripheral
// RULE17: digital input functions also need the direction bit set to input
// RULE18: software disables the peripheral before changing the select field
// RULE19: reset sets all data latches and direction bits to one
// RULE20: output without prior data write drives high from the latch
// RULE21: bit set and clear are read-modify-write of the whole port
// RULE22: in sleep, falling edge on a wake-enabled port A pin wakes device; the code only takes GPIO pins with direction 1
// RULE23: direction 1 is readable input, 0 is output from the data latch
// RULE24: a routed peripheral output drives the pin instead of the latch
`timescale 1ns/1ps

`include "pin_mux_params.svh"

module port_pin_function_mux
    import pin_mux_pkg::*;
(
    input  wire logic        CLK,
    input  wire logic        RST,
    input  wire logic        PSEL,
    input  wire logic        PENABLE,
    input  wire logic        PWRITE,
    input  wire logic [7:0]  PADDR,
    input  wire logic [31:0] PWDATA,
    output logic      [31:0] PRDATA,
    output logic             PREADY,
    output logic             PSLVERR,
    input  wire logic [7:0]  PA_IN,
    output logic      [7:0]  PA_OUT,
    output logic      [7:0]  PA_OE,
    input  wire logic [4:0]  PB_IN,
    output logic      [4:0]  PB_OUT,
    output logic      [4:0]  PB_OE,
    input  wire logic        TIMER_OUTPUT,
    input  wire logic        SLEEP_MODE,
    output logic             WAKE,
    output logic             EXT_INT_IN,
    output logic      [3:0]  ANALOG_CHANNEL_EN,
    output logic             OPAMP_NONINV_INPUT_EN,
    output logic             OPAMP_INV_INPUT_EN,
    output logic             OPAMP_OUTPUT_EN,
    output logic      [1:0]  BATTERY_SENSE_EN,
    output logic             TOUCH_PAD_ONE_EN,
    output logic             TOUCH_PAD_TWO_EN,
    output logic             VREF_INPUT_EN,
    output logic      [7:0]  SOURCE_CURRENT_SELECT
);

    // ----------------
    // Functions
    // ----------------

    // Function of a port A pin from its 2-bit select code
    function automatic pin_fn_t pa_fn(input int pin, input logic [1:0] code);
        pa_fn = FN_GPIO;
        unique case (pin)
            0: if (code == 2'b01) pa_fn = FN_ANALOG;       // see RULE5
               else if (code == 2'b10) pa_fn = FN_TMR;
            1: if (code == 2'b01) pa_fn = FN_ANALOG;       // see RULE4
               else if (code == 2'b10) pa_fn = FN_ANALOG;
               else if (code == 2'b11) pa_fn = FN_TMR;
            2: if (code == 2'b01 || code == 2'b10) pa_fn = FN_ANALOG; // see RULE3
            3: if (code == 2'b01) pa_fn = FN_ANALOG;       // see RULE2
            4: if (code == 2'b01) pa_fn = FN_ANALOG;       // see RULE8
            6: if (code == 2'b01 || code == 2'b10) pa_fn = FN_ANALOG; // see RULE7
               else if (code == 2'b11) pa_fn = FN_TMR_INV;
            7: if (code == 2'b01) pa_fn = FN_ANALOG;       // see RULE6
            default: pa_fn = FN_GPIO;                      // PA5 has no alternate
        endcase
    endfunction

    // Function of a port B pin from its 2-bit select code
    function automatic pin_fn_t pb_fn(input int pin, input logic [1:0] code);
        pb_fn = FN_GPIO;
        unique case (pin)
            0: if (code == 2'b01) pb_fn = FN_TMR;          // see RULE13
            1: if (code == 2'b01) pb_fn = FN_TMR_INV;      // see RULE12
            2: if (code == 2'b01 || code == 2'b10) pb_fn = FN_ANALOG; // see RULE11
            3: if (code == 2'b01) pb_fn = FN_ANALOG;       // see RULE10
            default: if (code == 2'b01) pb_fn = FN_TMR;    // see RULE14
        endcase
    endfunction

    // Pin level for a function: latch, timer, or inverted timer
    function automatic logic drive_level(input pin_fn_t fn, input logic latch_bit,
                                         input logic tmr);
        unique case (fn)
            FN_TMR:     drive_level = tmr;
            FN_TMR_INV: drive_level = ~tmr;
            default:    drive_level = latch_bit;
        endcase
    endfunction

    // ----------------
    // Registers and nets
    // ----------------
    logic [7:0]  pa_data_q;
    logic [7:0]  pa_dir_q;
    logic [7:0]  pa_wake_q;
    logic [4:0]  pb_data_q;
    logic [4:0]  pb_dir_q;
    logic [7:0]  pa_sel0_q;
    logic [7:0]  pa_sel1_q;
    logic [7:0]  pb_sel0_q;
    logic [1:0]  pb_sel1_q;
    logic [7:0]  src_cur_q;
    logic [7:0]  pa_meta_q;
    logic [7:0]  pa_sync_q;
    logic [7:0]  pa_prev_q;
    logic [4:0]  pb_meta_q;
    logic [4:0]  pb_sync_q;
    logic        pready_q;
    logic        pslverr_q;
    logic [31:0] prdata_q;
    logic [7:0]  pa_out_q;
    logic [7:0]  pa_oe_q;
    logic [4:0]  pb_out_q;
    logic [4:0]  pb_oe_q;
    logic        wake_q;
    logic        ext_int_q;
    logic [10:0] en_q;
    logic [15:0] pa_code;
    logic [9:0]  pb_code;
    pin_fn_t     pa_f [8];
    pin_fn_t     pb_f [5];
    logic        acc_done;
    logic        wr_en;
    logic        mapped;
    logic [31:0] rd_val;
    logic [7:0]  pa_fall;
    logic [7:0]  pa_gpio;

    // ----------------
    // APB slave
    // ----------------

    // One wait state: pready rises in the second access cycle
    assign acc_done = PSEL & PENABLE & pready_q;
    assign wr_en    = acc_done & PWRITE & mapped;

    // Address decode; unmapped offsets answer with an error
    always_comb begin
        mapped = 1'b1;
        rd_val = 32'h0000_0000;
        unique case (PADDR)
            // Inputs read the pin, outputs read the latch: see RULE23
            `OFS_PA_DATA: rd_val = {24'h0, (pa_sync_q & pa_dir_q) | (pa_data_q & ~pa_dir_q)};
            `OFS_PA_DIR:  rd_val = {24'h0, pa_dir_q};
            `OFS_PA_WAKE: rd_val = {24'h0, pa_wake_q};
            `OFS_PB_DATA: rd_val = {27'h0, (pb_sync_q & pb_dir_q) | (pb_data_q & ~pb_dir_q)};
            `OFS_PB_DIR:  rd_val = {27'h0, pb_dir_q};
            `OFS_PA_SEL0: rd_val = {24'h0, pa_sel0_q};
            `OFS_PA_SEL1: rd_val = {24'h0, pa_sel1_q & `MASK_PA_SEL1}; // see RULE9
            `OFS_PB_SEL0: rd_val = {24'h0, pb_sel0_q};
            `OFS_PB_SEL1: rd_val = {30'h0, pb_sel1_q};                // see RULE9
            `OFS_SRC_CUR: rd_val = {24'h0, src_cur_q};
            default:      mapped = 1'b0;
        endcase
    end

    // Handshake and read data, captured in the first access cycle
    always_ff @(posedge CLK) begin
        if (RST) begin
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q  <= 32'h0000_0000;
        end else begin
            pready_q  <= PSEL & PENABLE & ~pready_q;
            pslverr_q <= PSEL & PENABLE & ~pready_q & ~mapped;
            if (PSEL & PENABLE & ~pready_q & ~PWRITE) begin
                prdata_q <= rd_val;
            end
        end
    end

    // ----------------
    // Port latches
    // ----------------

    // Whole-byte writes only; a bit set or clear is read, modify,
    // write back, so input pins overwrite their latch bits
    always_ff @(posedge CLK) begin
        if (RST) begin
            pa_data_q <= `RST_PA_DATA;                     // see RULE19
            pa_dir_q  <= `RST_PA_DIR;                      // see RULE19
            pb_data_q <= `RST_PB_DATA;                     // see RULE19
            pb_dir_q  <= `RST_PB_DIR;                      // see RULE19
            pa_wake_q <= `RST_WAKE;
        end else if (wr_en) begin
            unique case (PADDR)
                `OFS_PA_DATA: pa_data_q <= PWDATA[7:0];    // see RULE21
                `OFS_PA_DIR:  pa_dir_q  <= PWDATA[7:0];
                `OFS_PA_WAKE: pa_wake_q <= PWDATA[7:0];
                `OFS_PB_DATA: pb_data_q <= PWDATA[4:0];    // see RULE21
                `OFS_PB_DIR:  pb_dir_q  <= PWDATA[4:0];
                default: ;
            endcase
        end
    end

    // ----------------
    // Select and source current registers
    // ----------------
    always_ff @(posedge CLK) begin
        if (RST) begin
            pa_sel0_q <= `RST_SEL;
            pa_sel1_q <= `RST_SEL;
            pb_sel0_q <= `RST_SEL;
            pb_sel1_q <= 2'b00;
            src_cur_q <= `RST_SRC_CUR;
        end else if (wr_en) begin
            unique case (PADDR)
                `OFS_PA_SEL0: pa_sel0_q <= PWDATA[7:0];
                `OFS_PA_SEL1: pa_sel1_q <= PWDATA[7:0] & `MASK_PA_SEL1; // see RULE9
                `OFS_PB_SEL0: pb_sel0_q <= PWDATA[7:0];
                `OFS_PB_SEL1: pb_sel1_q <= PWDATA[1:0];                // see RULE9
                `OFS_SRC_CUR: src_cur_q <= PWDATA[7:0];                // see RULE1
                default: ;
            endcase
        end
    end

    // ----------------
    // Pin input synchronisers
    // ----------------

    // Two flops before use; a third keeps the last level for edges
    always_ff @(posedge CLK) begin
        if (RST) begin
            pa_meta_q <= 8'hff;
            pa_sync_q <= 8'hff;
            pa_prev_q <= 8'hff;
            pb_meta_q <= 5'h1f;
            pb_sync_q <= 5'h1f;
        end else begin
            pa_meta_q <= PA_IN;
            pa_sync_q <= pa_meta_q;
            pa_prev_q <= pa_sync_q;
            pb_meta_q <= PB_IN;
            pb_sync_q <= pb_meta_q;
        end
    end

    // ----------------
    // Function decode
    // ----------------

    // Select codes gathered per pin; PA5 and unimplemented fields stay 00
    assign pa_code = {pa_sel1_q[7:6], pa_sel1_q[5:4], 2'b00, pa_sel1_q[1:0],
                      pa_sel0_q[7:6], pa_sel0_q[5:4], pa_sel0_q[3:2], pa_sel0_q[1:0]};
    assign pb_code = {pb_sel1_q, pb_sel0_q};

    always_comb begin
        for (int i = 0; i < 8; i++) begin
            pa_f[i] = pa_fn(i, pa_code[2*i +: 2]);
        end
        for (int i = 0; i < 5; i++) begin
            pb_f[i] = pb_fn(i, pb_code[2*i +: 2]);
        end
    end

    // ----------------
    // Pin drivers
    // ----------------

    // Timer functions always drive; analog ones release the pin;
    // GPIO drives the latch when direction is 0
    always_ff @(posedge CLK) begin
        if (RST) begin
            pa_out_q <= `RST_PA_DATA;
            pa_oe_q  <= 8'h00;
            pb_out_q <= `RST_PB_DATA;
            pb_oe_q  <= 5'h00;
        end else begin
            for (int i = 0; i < 8; i++) begin
                pa_out_q[i] <= drive_level(pa_f[i], pa_data_q[i], TIMER_OUTPUT); // see RULE24
                pa_oe_q[i]  <= (pa_f[i] == FN_TMR) | (pa_f[i] == FN_TMR_INV) |
                               ((pa_f[i] == FN_GPIO) & ~pa_dir_q[i]);    // see RULE23, RULE20
            end
            for (int i = 0; i < 5; i++) begin
                pb_out_q[i] <= drive_level(pb_f[i], pb_data_q[i], TIMER_OUTPUT); // see RULE24
                pb_oe_q[i]  <= (pb_f[i] == FN_TMR) | (pb_f[i] == FN_TMR_INV) |
                               ((pb_f[i] == FN_GPIO) & ~pb_dir_q[i]);    // see RULE23, RULE20
            end
        end
    end

    // ----------------
    // Peripheral connections
    // ----------------

    // Registered enables so every output leaves a flop; the interrupt
    // input follows PA0 only while that pin is in GPIO mode
    always_ff @(posedge CLK) begin
        if (RST) begin
            en_q      <= 11'h000;
            ext_int_q <= 1'b1;
        end else begin
            en_q[0]  <= pa_sel0_q[1:0] == 2'b01;                       // see RULE5
            en_q[1]  <= pa_sel0_q[3:2] == 2'b10;                       // see RULE4
            en_q[2]  <= pa_sel1_q[5:4] == 2'b10;                       // see RULE7
            en_q[3]  <= pa_sel1_q[7:6] == 2'b01;                       // see RULE6
            en_q[4]  <= (pa_sel0_q[7:6] == 2'b01) | (pa_sel1_q[5:4] == 2'b01); // see RULE2
            en_q[5]  <= pa_sel0_q[5:4] == 2'b01;                       // see RULE3
            en_q[6]  <= pa_sel0_q[3:2] == 2'b01;                       // see RULE4
            // Battery sense: both may be set, software keeps one, see RULE15
            en_q[7]  <= pa_sel0_q[5:4] == 2'b10;                       // see RULE3
            en_q[8]  <= pa_sel1_q[1:0] == 2'b01;                       // see RULE8
            en_q[9]  <= pb_sel0_q[5:4] == 2'b01;                       // see RULE11
            en_q[10] <= pb_sel0_q[7:6] == 2'b01;                       // see RULE10
            ext_int_q <= (pa_f[0] == FN_GPIO) ? pa_sync_q[0] : 1'b1;   // see RULE5
        end
    end

    logic vref_q;

    always_ff @(posedge CLK) begin
        if (RST) begin
            vref_q <= 1'b0;
        end else begin
            vref_q <= pb_sel0_q[5:4] == 2'b10;                         // see RULE11
        end
    end

    // ----------------
    // Port A wake-up
    // ----------------

    // Only GPIO input pins take part, so a pin driven by this block
    // cannot wake the device by its own falling output
    assign pa_gpio = {(pa_f[7] == FN_GPIO), (pa_f[6] == FN_GPIO), (pa_f[5] == FN_GPIO),
                      (pa_f[4] == FN_GPIO), (pa_f[3] == FN_GPIO), (pa_f[2] == FN_GPIO),
                      (pa_f[1] == FN_GPIO), (pa_f[0] == FN_GPIO)};
    assign pa_fall = pa_prev_q & ~pa_sync_q & pa_wake_q & pa_gpio & pa_dir_q;

    // One-cycle wake pulse on any enabled falling edge while asleep
    always_ff @(posedge CLK) begin
        if (RST) begin
            wake_q <= 1'b0;
        end else begin
            wake_q <= SLEEP_MODE & (|pa_fall);                         // see RULE22
        end
    end

    // ----------------
    // Outputs
    // ----------------
    assign PRDATA                = prdata_q;
    assign PREADY                = pready_q;
    assign PSLVERR               = pslverr_q;
    assign PA_OUT                = pa_out_q;
    assign PA_OE                 = pa_oe_q;
    assign PB_OUT                = pb_out_q;
    assign PB_OE                 = pb_oe_q;
    assign WAKE                  = wake_q;
    assign EXT_INT_IN            = ext_int_q;
    assign ANALOG_CHANNEL_EN     = en_q[3:0];
    assign OPAMP_NONINV_INPUT_EN = en_q[4];
    assign OPAMP_INV_INPUT_EN    = en_q[5];
    assign OPAMP_OUTPUT_EN       = en_q[6];
    assign BATTERY_SENSE_EN      = en_q[8:7];
    assign TOUCH_PAD_ONE_EN      = en_q[9];
    assign TOUCH_PAD_TWO_EN      = en_q[10];
    assign VREF_INPUT_EN         = vref_q;
    assign SOURCE_CURRENT_SELECT = src_cur_q;                          // see RULE1

endmodule

// ### verif/pin_mux_sva.sv
/* Port-level checker for the pin mux.
   Assumes one clock and a sync reset. */
`timescale 1ns/1ps
`include "pin_mux_params.svh"
module pin_mux_sva (
    input wire logic        CLK,
    input wire logic        RST,
    input wire logic        PSEL,
    input wire logic        PENABLE,
    input wire logic        PWRITE,
    input wire logic [7:0]  PADDR,
    input wire logic [31:0] PWDATA,
    input wire logic        PREADY,
    input wire logic        PSLVERR,
    input wire logic [7:0]  PA_OUT,
    input wire logic [7:0]  PA_OE,
    input wire logic        WAKE,
    input wire logic        SLEEP_MODE,
    input wire logic [3:0]  ANALOG_CHANNEL_EN,
    input wire logic        OPAMP_OUTPUT_EN,
    input wire logic        OPAMP_INV_INPUT_EN,
    input wire logic [1:0]  BATTERY_SENSE_EN,
    input wire logic [7:0]  SOURCE_CURRENT_SELECT
);
    default clocking cb @(posedge CLK); endclocking
    default disable iff (RST);
    // ----------------
    // Helpers and properties
    // ----------------
    logic done;
    assign done = PSEL && PENABLE && PREADY;
    property p_wait; PSEL && PENABLE && !PREADY |=> PREADY; endproperty
    property p_pulse; PREADY |=> !PREADY; endproperty
    property p_setup; PSEL && !PENABLE |-> !PREADY; endproperty
    // Only a hole in the map may be refused
    property p_err;
        PSLVERR |-> PREADY && (PADDR > `OFS_SRC_CUR || PADDR[1:0] != 2'h0);
    endproperty
    property p_src;
        $changed(SOURCE_CURRENT_SELECT) |-> SOURCE_CURRENT_SELECT == $past(PWDATA[7:0])
            && $past(done) && $past(PWRITE) && $past(PADDR) == `OFS_SRC_CUR;
    endproperty
    property p_wake; WAKE |-> $past(SLEEP_MODE); endproperty
    property p_rst; $fell(RST) |-> PA_OE == 8'h00 && PA_OUT == 8'hff && !WAKE; endproperty
    // The analog pads of PA0, PA2, PA4 and PA7 must never fight a driver
    property p_rel;
        (PA_OE & {ANALOG_CHANNEL_EN[3], 2'h0, BATTERY_SENSE_EN[1], 1'h0,
                  OPAMP_INV_INPUT_EN, 1'h0, ANALOG_CHANNEL_EN[0]}) == 8'h00;
    endproperty
    property p_excl;
        $onehot0({OPAMP_OUTPUT_EN, ANALOG_CHANNEL_EN[1]})
            && $onehot0({OPAMP_INV_INPUT_EN, BATTERY_SENSE_EN[0]});
    endproperty
    a_wait: assert property (p_wait) else $error("no answer after one wait");
    a_pulse: assert property (p_pulse) else $error("ready longer than a cycle");
    a_setup: assert property (p_setup) else $error("ready in setup cycle");
    a_err: assert property (p_err) else $error("error on a mapped address");
    a_src: assert property (p_src) else $error("source current bad update");
    a_wake: assert property (p_wake) else $error("wake while awake");
    a_rst: assert property (p_rst) else $error("pins not inputs after reset");
    a_rel: assert property (p_rel) else $error("analog pin driven");
    a_excl: assert property (p_excl) else $error("two functions on a pin");
    c_wr: cover property (done && PWRITE);
    c_err: cover property (PSLVERR);
    c_wake: cover property (WAKE);
    c_bat: cover property (BATTERY_SENSE_EN[1]);
endmodule
bind port_pin_function_mux pin_mux_sva chk_u (.CLK(CLK), .RST(RST), .PSEL(PSEL),
    .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PREADY(PREADY),
    .PSLVERR(PSLVERR), .PA_OUT(PA_OUT), .PA_OE(PA_OE), .WAKE(WAKE), .SLEEP_MODE(SLEEP_MODE),
    .ANALOG_CHANNEL_EN(ANALOG_CHANNEL_EN), .OPAMP_OUTPUT_EN(OPAMP_OUTPUT_EN),
    .OPAMP_INV_INPUT_EN(OPAMP_INV_INPUT_EN), .BATTERY_SENSE_EN(BATTERY_SENSE_EN),
    .SOURCE_CURRENT_SELECT(SOURCE_CURRENT_SELECT));

// ### verif/pin_world.sv
/* Far side of the mux: pins and the timer.
   Assumes the bench sets the outside level of idle pins. */
`timescale 1ns/1ps
module pin_world (
    input  wire logic       clk,
    input  wire logic [7:0] pa_out,
    input  wire logic [7:0] pa_oe,
    input  wire logic [4:0] pb_out,
    input  wire logic [4:0] pb_oe,
    input  wire logic [7:0] pa_ext,
    input  wire logic [4:0] pb_ext,
    input  wire logic       tmr_lvl,
    output logic      [7:0] pa_in,
    output logic      [4:0] pb_in,
    output logic            tmr_out
);
    // A driven pin shows its driver, a released one the outside level
    assign pa_in = (pa_oe & pa_out) | (~pa_oe & pa_ext);
    assign pb_in = (pb_oe & pb_out) | (~pb_oe & pb_ext);
    // Timer output leaves a flop, as a real timer on this clock would
    always_ff @(posedge clk) begin
        tmr_out <= tmr_lvl;
    end
endmodule

// ### verif/tb_top.sv
/* Self-checking bench for the pin mux.
   Assumes a 100 MHz clock and the pin model. */
`timescale 1ns/1ps
`include "pin_mux_params.svh"
module tb_top;
    logic        clk = 1'h0, rst = 1'h1, psel = 1'h0, pen = 1'h0, pwr = 1'h0;
    logic        sleep = 1'h0, tmr = 1'h0;
    logic [7:0]  paddr = 8'h00;
    logic [7:0]  pa_ext = 8'ha4;
    logic [4:0]  pb_ext = 5'h0a;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic        pready, pslverr, wake, ext_int, op_ni, op_inv, op_o, tp1, tp2, vref, tmr_o;
    logic [7:0]  pa_in, pa_out, pa_oe, src;
    logic [4:0]  pb_in, pb_out, pb_oe;
    logic [3:0]  an;
    logic [1:0]  bat;
    int          miscompares = 0;
    int          cmp_count = 0;
    always #5 clk = ~clk;
    port_pin_function_mux dut_u (.CLK(clk), .RST(rst), .PSEL(psel), .PENABLE(pen),
        .PWRITE(pwr), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
        .PSLVERR(pslverr), .PA_IN(pa_in), .PA_OUT(pa_out), .PA_OE(pa_oe), .PB_IN(pb_in),
        .PB_OUT(pb_out), .PB_OE(pb_oe), .TIMER_OUTPUT(tmr_o), .SLEEP_MODE(sleep),
        .WAKE(wake), .EXT_INT_IN(ext_int), .ANALOG_CHANNEL_EN(an),
        .OPAMP_NONINV_INPUT_EN(op_ni), .OPAMP_INV_INPUT_EN(op_inv), .OPAMP_OUTPUT_EN(op_o),
        .BATTERY_SENSE_EN(bat), .TOUCH_PAD_ONE_EN(tp1), .TOUCH_PAD_TWO_EN(tp2),
        .VREF_INPUT_EN(vref), .SOURCE_CURRENT_SELECT(src));
    pin_world world_u (.clk(clk), .pa_out(pa_out), .pa_oe(pa_oe), .pb_out(pb_out),
        .pb_oe(pb_oe), .pa_ext(pa_ext), .pb_ext(pb_ext), .tmr_lvl(tmr), .pa_in(pa_in),
        .pb_in(pb_in), .tmr_out(tmr_o));
    // ----------------
    // Shared tasks
    // ----------------
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            miscompares++;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic wt(input int n);
        repeat (n) @(posedge clk);
    endtask
    // Request held until ready is sampled high, then released
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] rd, output logic err);
        int n;
        n = 0;
        @(posedge clk);
        psel <= 1'h1;
        pwr <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        pen <= 1'h1;
        do @(posedge clk); while (pready !== 1'h1 && ++n < 20);
        if (n >= 20) miscompares++;
        rd = prdata;
        err = pslverr;
        psel <= 1'h0;
        pen <= 1'h0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic        e;
        apb(1'h1, a, d, r, e);
    endtask
    task automatic rd_chk(input string nm, input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] r;
        logic        e;
        apb(1'h0, a, 32'h0, r, e);
        chk(nm, r, exp);
    endtask
    task automatic cnt_wake(output logic [31:0] k);
        k = 32'h0;
        repeat (8) begin
            @(posedge clk);
            if (wake === 1'h1) k++;
        end
    endtask
    // ----------------
    // Scenarios
    // ----------------
    task automatic t_reset;
        chk("pa_oe", 32'(pa_oe), 32'h0);
        chk("pb_out", 32'({pa_out, pb_out}), 32'h1fff);
        rd_chk("pa_dir", `OFS_PA_DIR, 32'hff);
        rd_chk("pb_dir", `OFS_PB_DIR, 32'h1f);
        rd_chk("pa_rd", `OFS_PA_DATA, 32'ha4);
        rd_chk("src", `OFS_SRC_CUR, 32'h0);
    endtask
    task automatic t_out;
        wr(`OFS_PA_DIR, 32'hfe);
        wt(2);
        chk("out0", 32'({pa_oe[0], pa_out[0]}), 32'h3);
        wr(`OFS_PA_DATA, 32'h00);
        wt(2);
        chk("out0", 32'(pa_out[0]), 32'h0);
        rd_chk("pa_rd", `OFS_PA_DATA, 32'ha4);
        // Set bit 6 the way software does it: read, change, write the byte
        wr(`OFS_PA_DATA, 32'ha4 | 32'h40);
        wr(`OFS_PA_DIR, 32'h00);
        wt(2);
        chk("rmw", 32'(pa_out), 32'he4);
        wr(`OFS_PA_DIR, 32'hff);
    endtask
    task automatic t_sel;
        logic [31:0] v;
        logic        k1, k2, k3;
        for (int c = 0; c < 4; c++) begin
            v = 32'({4{c[1:0]}});
            k1 = (c == 1);
            k2 = (c == 2);
            k3 = (c == 3);
            tmr <= c[0];
            // Same code in all fields; battery sense never on both pins
            wr(`OFS_PA_SEL0, v);
            wr(`OFS_PA_SEL1, v);
            wr(`OFS_PB_SEL0, v);
            wr(`OFS_PB_SEL1, v);
            wt(2);
            chk("op", 32'({op_ni, op_inv, op_o}), 32'({3{k1}}));
            chk("bat", 32'(bat), 32'({k1, k2}));
            chk("an", 32'(an), 32'({k1, k2, k2, k1}));
            chk("ext_int", 32'(ext_int), 32'(k1 | k2));
            chk("pa_oe", 32'(pa_oe), 32'({1'h0, k3, 4'h0, k3, k2}));
            chk("pb_oe", 32'(pb_oe), 32'({k1, 2'h0, k1, k1}));
            chk("pads", 32'({tp1, tp2, vref}), 32'({k1, k1, k2}));
            if (k3) chk("pa_out", 32'(pa_out), 32'ha6);
            if (k1) chk("pb_out", 32'(pb_out & 5'h13), 32'h11);
            rd_chk("sel1", `OFS_PA_SEL1, v & 32'hf3);
            rd_chk("sel1b", `OFS_PB_SEL1, v & 32'h03);
            rd_chk("sel0", `OFS_PA_SEL0, v);
        end
        // No peripheral is running, so the pins may go back to GPIO
        wr(`OFS_PA_SEL0, 32'h0);
        wr(`OFS_PA_SEL1, 32'h0);
        wr(`OFS_PB_SEL0, 32'h0);
        wr(`OFS_PB_SEL1, 32'h0);
    endtask
    task automatic t_misc;
        logic [31:0] r;
        logic        e;
        wr(`OFS_SRC_CUR, 32'he4);
        wt(2);
        chk("src", 32'(src), 32'he4);
        apb(1'h1, 8'h28, 32'h0, r, e);
        chk("slverr", 32'(e), 32'h1);
    endtask
    task automatic t_wake;
        logic [31:0] k;
        wr(`OFS_PA_WAKE, 32'h20);
        sleep <= 1'h1;
        pa_ext <= 8'h24;
        cnt_wake(k);
        chk("nowake", k, 32'h0);
        pa_ext <= 8'h04;
        cnt_wake(k);
        chk("wake", k, 32'h1);
        sleep <= 1'h0;
        pa_ext <= 8'h24;
        wt(8);
        pa_ext <= 8'h04;
        cnt_wake(k);
        chk("awake", k, 32'h0);
    endtask
    task automatic print_verdict;
        $display("Comparisons %0d, mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    // Watchdog: the whole run needs well under a thousand cycles
    initial begin
        wt(5000);
        miscompares++;
        print_verdict;
    end
    initial begin
        wt(16);
        rst <= 1'h0;
        wt(1);
        t_reset;
        t_out;
        t_sel;
        t_misc;
        t_wake;
        print_verdict;
    end
endmodule
